// ===== bench/uart_rx_error_irq_wakeup_test.sv
// Self-checking bench of the serial receive error, interrupt and wake-up block
`timescale 1ns/1ps
module uart_rx_error_irq_wakeup_test;
   import urx_pkg::*;
   localparam int RES = 16;
   localparam int LIMIT = 20000;
   localparam logic [7:0] PC1 [5] = '{8'h0a, 8'h0a, 8'h0e, 8'h0e, 8'h08};
   localparam logic [4:0] PPAR = 5'b11001;
   localparam logic [4:0] PEXP = 5'b00101;
   localparam logic [4:0] PFB = 5'b00010;
   localparam logic [7:0] AC1 [5] = '{8'h08, 8'h08, 8'h09, 8'h09, 8'h08};
   localparam logic [7:0] AC2 [5] = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h03};
   localparam logic [8:0] AW [5] = '{9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h000};
   localparam logic [4:0] AIRQ = 5'b11010;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic power_down = 1'b0, global_irq_enable = 1'b1, stack_full = 1'b0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, irq_pending, irq_branch, tx_load, tx_force_high;
   logic transfer_abort, rx_ignore, wake_up, rx_done, rx_parity_bit, rx_stop_bad;
   logic tx_empty_set, tx_idle_set, rx_pin;
   logic [8:0] rx_word, tx_data;
   logic [7:0] baud_rate, ctrl_one, ctrl_two;
   int n_fail = 0, samples_checked = 0, cycles = 0;

   // Clock and hang guard
   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         stop_test;
      end
   end

   urx_core #(.RESUME_CYCLES(RES), .RX_DEPTH(RX_FIFO_DEPTH)) DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_done, .rx_word, .rx_parity_bit, .rx_stop_bad, .tx_empty_set,
      .tx_idle_set, .power_down, .global_irq_enable, .stack_full, .rx_pin, .irq_pending,
      .irq_branch, .tx_load, .tx_data, .baud_rate, .ctrl_one, .ctrl_two, .tx_force_high,
      .transfer_abort, .rx_ignore, .wake_up
   );
   urx_far_end far (
      .pclk, .rx_done, .rx_word, .rx_parity_bit, .rx_stop_bad, .tx_empty_set,
      .tx_idle_set, .rx_pin
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic stop_test;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Look at the answer mid-cycle, then finish at the edge that samples it
      @(negedge pclk);
      while (pready !== 1'b1) @(negedge pclk);
      rdat = prdata;
      rerr = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      chk("ctrl_one", ctrl_one, CTRL_RESET);
      chk("ctrl_two", ctrl_two, CTRL_RESET);
      rd(8'h1c);
      chk("unmapped err", rerr, 1'b1);
      chk("unmapped data", rdat, 32'h0);
   endtask

   // Each case word followed by a clean word, read back flags then data
   task automatic t_parity;
      wr(ADDR_CTRL2, 32'h01);
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL1, PC1[i]);
         far.send(9'h003, PPAR[i], PFB[i]);
         far.send(9'h000, PC1[i][C1_PARODD], 1'b0);
         rd(ADDR_STATUS);
         chk("parity_error_flag", rdat[ST_PAR_ERR], PEXP[i]);
         chk("framing_error_flag", rdat[ST_FRAME_ERR], PFB[i]);
         rd(ADDR_RXBUF);
         chk("word", rdat[7:0], 8'h03);
         rd(ADDR_STATUS);
         chk("parity_error_flag next", rdat[ST_PAR_ERR], 1'b0);
         rd(ADDR_RXBUF);
      end
   endtask

   task automatic t_irq;
      wr(ADDR_CTRL1, 32'h08);
      wr(ADDR_CTRL2, 32'h03);
      wr(ADDR_IRQ_CTRL, 32'h01);
      far.send(9'h055, 1'b0, 1'b0);
      cyc(4);
      chk("rx irq", irq_pending, 1'b1);
      chk("branch", irq_branch, 1'b1);
      stack_full <= 1'b1;
      cyc(3);
      chk("branch full", irq_branch, 1'b0);
      stack_full <= 1'b0;
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS);
      chk("rxf kept", rdat[ST_RXF], 1'b1);
      wr(ADDR_IRQ_CTRL, 32'h00);
      cyc(3);
      chk("irq gated", irq_pending, 1'b0);
      wr(ADDR_IRQ_CTRL, 32'h01);
      wr(ADDR_CTRL2, 32'h01);
      cyc(3);
      chk("irq rie off", irq_pending, 1'b0);
      wr(ADDR_CTRL2, 32'h03);
      far.send(9'h0aa, 1'b0, 1'b0);
      far.send(9'h0cc, 1'b0, 1'b0);
      rd(ADDR_STATUS);
      chk("ovr set", rdat[ST_OVR], 1'b1);
      rd(ADDR_RXBUF);
      chk("pop1", rdat[7:0], 8'h55);
      rd(ADDR_STATUS);
      chk("ovr clr", rdat[ST_OVR], 1'b0);
      rd(ADDR_RXBUF);
      chk("pop2", rdat[7:0], 8'haa);
      cyc(3);
      chk("irq empty", irq_pending, 1'b0);
   endtask

   task automatic t_tx;
      int k;
      rd(ADDR_STATUS);
      wr(ADDR_TXDATA, 32'h0);
      wr(ADDR_CTRL2, 32'h04);
      far.pulse(1'b1, 1'b0);
      cyc(4);
      chk("empty irq", irq_pending, 1'b1);
      wr(ADDR_CTRL2, 32'h08);
      cyc(3);
      chk("idle masked", irq_pending, 1'b0);
      far.pulse(1'b0, 1'b1);
      cyc(4);
      chk("idle irq", irq_pending, 1'b1);
      rd(ADDR_STATUS);
      chk("tempty", rdat[ST_TEMPTY], 1'b1);
      wr(ADDR_TXDATA, 32'h1a5);
      k = 0;
      repeat (3) begin
         @(negedge pclk);
         k += tx_load;
      end
      chk("tx_load", k, 1);
      chk("tx_data", tx_data, 9'h1a5);
      rd(ADDR_STATUS);
      chk("tx flags clr", rdat[ST_TEMPTY:ST_TX_IDLE], 2'b00);
      chk("tx irq clr", irq_pending, 1'b0);
   endtask

   task automatic t_addr;
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL1, AC1[i]);
         wr(ADDR_CTRL2, AC2[i]);
         far.send(AW[i], 1'b0, 1'b0);
         cyc(4);
         chk("addr irq", irq_pending, AIRQ[i]);
         rd(ADDR_STATUS);
         rd(ADDR_RXBUF);
         chk("addr word", rdat[7:0], AW[i][7:0]);
         cyc(3);
      end
   endtask

   task automatic t_wake(input logic glob, input logic exp);
      int k;
      int n;
      logic early;
      global_irq_enable <= glob;
      wr(ADDR_CTRL1, 32'h08);
      wr(ADDR_CTRL2, 32'h23);
      wr(ADDR_BAUD, 32'h5a);
      stack_full <= 1'b1;
      power_down <= 1'b1;
      k = 0;
      repeat (4) begin
         @(negedge pclk);
         k += transfer_abort;
      end
      chk("abort", k, 1);
      chk("tx high", tx_force_high, 1'b1);
      far.send(9'h033, 1'b0, 1'b0);
      chk("ctrl kept", ctrl_two, 8'h23);
      chk("baud kept", baud_rate, 8'h5a);
      fork
         far.pin_fall();
      join_none
      for (k = 0; k < 12 && wake_up !== 1'b1; k++) @(negedge pclk);
      chk("wake", wake_up, 1'b1);
      @(posedge pclk);
      power_down <= 1'b0;
      for (k = 0; k < 20 && rx_ignore !== 1'b1; k++) @(negedge pclk);
      fork
         far.send(9'h0f0, 1'b0, 1'b0);
      join_none
      n = 0;
      early = 1'b0;
      while (rx_ignore === 1'b1 && n < RES + 50) begin
         if (irq_pending !== 1'b0) early = 1'b1;
         @(negedge pclk);
         n++;
      end
      chk("resume len", n, RES);
      chk("early irq", early, 1'b0);
      cyc(4);
      chk("wake irq", irq_pending, exp);
      stack_full <= 1'b0;
      cyc(4);
      chk("wake served", irq_pending, 1'b0);
      rd(ADDR_STATUS);
      chk("no rx", rdat[ST_RXF], 1'b0);
   endtask

   // Reset, then the scenarios in order
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_parity;
      t_irq;
      t_tx;
      t_addr;
      t_wake(1'b1, 1'b1);
      t_wake(1'b0, 1'b0);
      stop_test;
   end
endmodule

// ===== bench/urx_far_end.sv
// Model of the remote serial end: word completions, transmitter events, receive pin
`timescale 1ns/1ps
module urx_far_end (
   input wire logic pclk,
   output logic rx_done,
   output logic [8:0] rx_word,
   output logic rx_parity_bit,
   output logic rx_stop_bad,
   output logic tx_empty_set,
   output logic tx_idle_set,
   output logic rx_pin
);
   // Idle line high, no events
   initial begin
      rx_done = 1'b0;
      rx_word = 9'h000;
      rx_parity_bit = 1'b0;
      rx_stop_bad = 1'b0;
      tx_empty_set = 1'b0;
      tx_idle_set = 1'b0;
      rx_pin = 1'b1;
   end

   // ****************************************************************
   // Transfers
   // ****************************************************************
   // One completed word; qualifiers turn to garbage once the pulse ends
   task automatic send(input logic [8:0] w, input logic p, input logic fb);
      @(posedge pclk);
      rx_done <= 1'b1;
      rx_word <= w;
      rx_parity_bit <= p;
      rx_stop_bad <= fb;
      @(posedge pclk);
      rx_done <= 1'b0;
      rx_word <= ~w;
      rx_parity_bit <= ~p;
      rx_stop_bad <= ~fb;
   endtask

   // Transmitter event pulses
   task automatic pulse(input logic e, input logic i);
      @(posedge pclk);
      tx_empty_set <= e;
      tx_idle_set <= i;
      @(posedge pclk);
      tx_empty_set <= 1'b0;
      tx_idle_set <= 1'b0;
   endtask

   // Start-bit style low going edge on the pin
   task automatic pin_fall;
      @(posedge pclk);
      rx_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      rx_pin <= 1'b1;
   endtask
endmodule

// ===== logic/urx_core.sv
// Serial port receive errors, interrupt combiner, power-down and wake-up
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module urx_core
   import urx_pkg::*;
#(
   parameter int RESUME_CYCLES = RESUME_SYS_CLOCKS,
   parameter int RX_DEPTH = RX_FIFO_DEPTH
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_done,
   input wire logic [8:0] rx_word,
   input wire logic rx_parity_bit,
   input wire logic rx_stop_bad,
   input wire logic tx_empty_set,
   input wire logic tx_idle_set,
   input wire logic power_down,
   input wire logic global_irq_enable,
   input wire logic stack_full,
   input wire logic rx_pin,
   output logic irq_pending,
   output logic irq_branch,
   output logic tx_load,
   output logic [8:0] tx_data,
   output logic [7:0] baud_rate,
   output logic [7:0] ctrl_one,
   output logic [7:0] ctrl_two,
   output logic tx_force_high,
   output logic transfer_abort,
   output logic rx_ignore,
   output logic wake_up
);

   localparam int PW = $clog2(RX_DEPTH);
   localparam logic [10:0] RESUME_LOAD = 11'(RESUME_CYCLES);
   localparam logic [PW:0] DEPTH_CNT = (PW+1)'(RX_DEPTH);

   // Highest received bit: ninth in 9-bit mode, else eighth
   function automatic logic msb_of(input logic [8:0] w, input logic nine);
      msb_of = nine ? w[8] : w[7];
   endfunction

   // Parity check over the data bits and the parity bit
   function automatic logic par_bad(input logic [8:0] w, input logic nine,
                                    input logic pbit, input logic odd);
      logic [8:0] d;
      d = nine ? w : {1'b0, w[7:0]};
      par_bad = ((^d) ^ pbit) != odd;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic [7:0] cfg1_reg, cfg2_reg, intc_reg, baud_reg;
   logic tx_load_reg;
   logic [8:0] tx_data_reg;
   logic st_access_reg, st_access_next;
   logic te_reg, te_next, ti_reg, ti_next, ovr_reg, ovr_next;
   urx_entry_s fifo_q [RX_DEPTH];
   logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [PW:0] cnt_reg, cnt_next;
   logic irq_reg, irq_next, branch_reg, branch_next;
   logic armed_reg, wake_latch, ws1_reg, ws2_reg, wake_clr_reg;
   logic [10:0] resume_reg, resume_next;
   logic wake_pend_reg, wake_pend_next;
   logic ignore_reg, force_reg, abort_reg, pd_prev_reg;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   wire setup = psel & ~penable;
   wire acc = psel & penable & pready_reg;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire hit_st = paddr == ADDR_STATUS;
   wire hit_c1 = paddr == ADDR_CTRL1;
   wire hit_c2 = paddr == ADDR_CTRL2;
   wire hit_rx = paddr == ADDR_RXBUF;
   wire hit_tx = paddr == ADDR_TXDATA;
   wire hit_bd = paddr == ADDR_BAUD;
   wire hit_ic = paddr == ADDR_IRQ_CTRL;
   wire mapped = hit_st | hit_c1 | hit_c2 | hit_rx | hit_tx | hit_bd | hit_ic;
   wire cfg_wr = wr & ~power_down;

   // Control bits used by the logic
   wire nine = cfg1_reg[C1_NINE];
   wire par_en = cfg1_reg[C1_PAREN];
   wire par_odd = cfg1_reg[C1_PARODD];
   wire uen = cfg1_reg[C1_UEN];
   wire rx_en = cfg2_reg[C2_RECEIVER_ENABLE];
   wire rx_irq_en = cfg2_reg[C2_RX_IRQ];
   wire teie = cfg2_reg[C2_TEIE];
   wire tiie = cfg2_reg[C2_TIIE];
   wire addr_det_en = cfg2_reg[C2_ADDR_DET];
   wire wake_en = cfg2_reg[C2_WAKE];
   wire serial_irq_en = intc_reg[IC_SERIAL_IRQ];

   // ****************************************************************
   // Receive buffer
   // ****************************************************************
   wire busy = resume_reg != 11'h000;
   wire rx_empty = cnt_reg == '0;
   wire rx_full = cnt_reg == DEPTH_CNT;
   wire rx_accept = rx_done & uen & rx_en & ~busy & ~power_down;
   wire push = rx_accept & ~rx_full;
   wire ovr_set = rx_accept & rx_full;
   wire pop = rd & hit_rx & ~rx_empty;
   urx_entry_s new_entry;
   urx_entry_s head;
   assign head = fifo_q[rd_ptr_reg];
   assign new_entry.word = nine ? rx_word : {1'b0, rx_word[7:0]};
   assign new_entry.parity_error_flag = par_en & par_bad(rx_word, nine, rx_parity_bit, par_odd);
   assign new_entry.framing_error_flag = rx_stop_bad;
   assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);

   // Buffer storage, cleared on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < RX_DEPTH; i++) begin
            fifo_q[i] <= '0;
         end
      end else if (push) begin
         fifo_q[wr_ptr_reg] <= new_entry;
      end
   end

   // Buffer pointers and fill count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************************************
   // Status flags, set wins over clear
   // ****************************************************************
   wire rx_rd_seq = rd & hit_rx & st_access_reg;
   wire tx_wr_seq = wr & hit_tx & st_access_reg;
   assign st_access_next = (rd & hit_st) | (st_access_reg & ~(rd & hit_rx) & ~(wr & hit_tx));
   assign ovr_next = ovr_set | (ovr_reg & ~rx_rd_seq);
   assign te_next = tx_empty_set | (te_reg & ~tx_wr_seq);
   assign ti_next = tx_idle_set | (ti_reg & ~tx_wr_seq);

   // Flag and access-sequence registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_access_reg <= 1'b0;
         ovr_reg <= 1'b0;
         te_reg <= 1'b0;
         ti_reg <= 1'b0;
      end else begin
         st_access_reg <= st_access_next;
         ovr_reg <= ovr_next;
         te_reg <= te_next;
         ti_reg <= ti_next;
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   wire [7:0] status_word = {2'b00, te_reg, ti_reg, ~rx_empty, ovr_reg,
                             head.framing_error_flag & ~rx_empty, head.parity_error_flag & ~rx_empty};
   wire [7:0] c1_view = {head.word[8], cfg1_reg[6:0]};
   wire [8:0] rd_mux = hit_st ? {1'b0, status_word} :
                       hit_c1 ? {1'b0, c1_view} :
                       hit_c2 ? {1'b0, cfg2_reg} :
                       hit_rx ? head.word :
                       hit_tx ? tx_data_reg :
                       hit_bd ? {1'b0, baud_reg} :
                       hit_ic ? {1'b0, intc_reg} : 9'h000;

   // APB answer: one access cycle, error on unmapped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         prdata_reg <= setup ? {23'h00_0000, rd_mux} : prdata_reg;
      end
   end

   // Software-written registers, frozen in power-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg1_reg <= CTRL_RESET;
         cfg2_reg <= CTRL_RESET;
         intc_reg <= CTRL_RESET;
         baud_reg <= CTRL_RESET;
         tx_data_reg <= 9'h000;
         tx_load_reg <= 1'b0;
      end else begin
         cfg1_reg <= (cfg_wr & hit_c1) ? pwdata[7:0] : cfg1_reg;
         cfg2_reg <= (cfg_wr & hit_c2) ? pwdata[7:0] : cfg2_reg;
         intc_reg <= (cfg_wr & hit_ic) ? pwdata[7:0] : intc_reg;
         baud_reg <= (cfg_wr & hit_bd) ? pwdata[7:0] : baud_reg;
         tx_data_reg <= (cfg_wr & hit_tx) ? pwdata[8:0] : tx_data_reg;
         tx_load_reg <= cfg_wr & hit_tx;
      end
   end

   // ****************************************************************
   // Interrupt combiner
   // ****************************************************************
   wire rx_src = rx_irq_en & ~rx_empty & (~addr_det_en | msb_of(head.word, nine));
   wire src_any = (te_reg & teie) | (ti_reg & tiie) | rx_src | (rx_irq_en & ovr_reg) | wake_pend_reg;
   assign irq_next = serial_irq_en & ~busy & ~power_down & src_any;
   assign branch_next = irq_reg & global_irq_enable & ~stack_full;

   // Request and branch registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
         branch_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
         branch_reg <= branch_next;
      end
   end

   // ****************************************************************
   // Power-down and receive-pin wake-up
   // ****************************************************************
   wire wake_clr_n = presetn & ~wake_clr_reg;
   wire wake_start = ws2_reg & ~wake_clr_reg;
   wire wake_irq_ok = global_irq_enable & serial_irq_en & rx_irq_en & wake_en;
   assign resume_next = wake_start ? RESUME_LOAD : (busy ? resume_reg - 11'h001 : resume_reg);
   assign wake_pend_next = (resume_reg == 11'h001 & wake_irq_ok) | (wake_pend_reg & ~branch_reg);

   // Falling edge on the pin sets the latch with clocks stopped
   always_ff @(negedge rx_pin or negedge wake_clr_n) begin
      if (!wake_clr_n) begin
         wake_latch <= 1'b0;
      end else if (armed_reg) begin
         wake_latch <= 1'b1;
      end
   end

   // Arming, synchroniser, resume delay, power-down pin control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
         ws1_reg <= 1'b0;
         ws2_reg <= 1'b0;
         wake_clr_reg <= 1'b0;
         resume_reg <= 11'h000;
         wake_pend_reg <= 1'b0;
         ignore_reg <= 1'b0;
         force_reg <= 1'b0;
         abort_reg <= 1'b0;
         pd_prev_reg <= 1'b0;
      end else begin
         armed_reg <= power_down & wake_en & uen & rx_en & rx_irq_en;
         ws1_reg <= wake_latch;
         ws2_reg <= ws1_reg;
         wake_clr_reg <= ws2_reg;
         resume_reg <= resume_next;
         wake_pend_reg <= wake_pend_next;
         ignore_reg <= resume_next != 11'h000;
         force_reg <= power_down;
         abort_reg <= power_down & ~pd_prev_reg;
         pd_prev_reg <= power_down;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq_pending = irq_reg;
   assign irq_branch = branch_reg;
   assign tx_load = tx_load_reg;
   assign tx_data = tx_data_reg;
   assign baud_rate = baud_reg;
   assign ctrl_one = cfg1_reg;
   assign ctrl_two = cfg2_reg;
   assign tx_force_high = force_reg;
   assign transfer_abort = abort_reg;
   assign rx_ignore = ignore_reg;
   assign wake_up = wake_latch;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   chk_parity_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      push && !par_en |=> !fifo_q[$past(wr_ptr_reg)].parity_error_flag)
      else $error("parity flag set with checking off");

   chk_flag_buffered: assert property (
      @(posedge pclk) disable iff (!presetn)
      push |=> fifo_q[$past(wr_ptr_reg)].parity_error_flag == $past(new_entry.parity_error_flag))
      else $error("parity flag not stored with word");

   chk_branch_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      branch_reg |-> $past(irq_reg && global_irq_enable && !stack_full))
      else $error("branch without enable or with full stack");

   chk_overall_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !serial_irq_en |=> !irq_reg)
      else $error("interrupt raised with serial enable off");

   chk_addr_qual: assert property (
      @(posedge pclk) disable iff (!presetn)
      serial_irq_en && !busy && !power_down && rx_irq_en && !rx_empty && addr_det_en && msb_of(head.word, nine)
      |=> irq_reg)
      else $error("address word raised no interrupt");

   chk_rx_every: assert property (
      @(posedge pclk) disable iff (!presetn)
      serial_irq_en && !busy && !power_down && rx_irq_en && !rx_empty && !addr_det_en |=> irq_reg)
      else $error("received word raised no interrupt");

   chk_ovr_sticky: assert property (
      @(posedge pclk) disable iff (!presetn)
      ovr_reg && !(rd && hit_rx && st_access_reg) |=> ovr_reg)
      else $error("overrun cleared without sequence");

   chk_tx_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr && hit_tx && st_access_reg && !tx_empty_set |=> !te_reg)
      else $error("transmit empty not cleared");

   chk_resume_len: assert property (
      @(posedge pclk) disable iff (!presetn)
      wake_start |=> resume_reg == RESUME_LOAD ##1 ignore_reg [*8])
      else $error("resume delay wrong");

   chk_resume_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      busy |=> !irq_reg)
      else $error("interrupt during resume delay");

   chk_pd_force: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(power_down) |=> tx_force_high && transfer_abort)
      else $error("power-down did not force pin");

   cov_overrun: cover property (@(posedge pclk) disable iff (!presetn) ovr_set);
   cov_wake: cover property (@(posedge pclk) disable iff (!presetn) $fell(busy) && wake_pend_reg);
   cov_branch: cover property (@(posedge pclk) disable iff (!presetn) addr_det_en && rx_src ##1 branch_next);

endmodule

// ===== shared/urx_pkg.sv
// Constants, register map and carrier types of the serial receive error/irq block
package urx_pkg;

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CTRL1 = 8'h04;
   localparam logic [7:0] ADDR_CTRL2 = 8'h08;
   localparam logic [7:0] ADDR_RXBUF = 8'h0c;
   localparam logic [7:0] ADDR_TXDATA = 8'h10;
   localparam logic [7:0] ADDR_BAUD = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h18;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int ST_PAR_ERR = 0;
   localparam int ST_FRAME_ERR = 1;
   localparam int ST_OVR = 2;
   localparam int ST_RXF = 3;
   localparam int ST_TX_IDLE = 4;
   localparam int ST_TEMPTY = 5;
   localparam int C1_NINE = 0;
   localparam int C1_PAREN = 1;
   localparam int C1_PARODD = 2;
   localparam int C1_UEN = 3;
   localparam int C1_RX8 = 7;
   localparam int C2_RECEIVER_ENABLE = 0;
   localparam int C2_RX_IRQ = 1;
   localparam int C2_TEIE = 2;
   localparam int C2_TIIE = 3;
   localparam int C2_ADDR_DET = 4;
   localparam int C2_WAKE = 5;
   localparam int IC_SERIAL_IRQ = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ****************************************************************
   // Timing and buffer depth
   // ****************************************************************
   localparam int RESUME_SYS_CLOCKS = 1024;
   localparam int RX_FIFO_DEPTH = 2;

   // One buffered received word with its own error flags
   typedef struct packed {
      logic [8:0] word;
      logic parity_error_flag;
      logic framing_error_flag;
   } urx_entry_s;

endpackage
